// ---- hdl/rtc_port_pkg.sv ----
// Constants for the clock/RAM serial port and status flags
package rtc_port_pkg;
  // Clock rate and derived counts
  localparam int CLK_MHZ = 250;
  localparam int WDOG_TIMEOUT_US = 1000;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_US * CLK_MHZ;
  localparam int HOST_RESET_NS = 100;
  localparam int HOST_RESET_CYCLES = (HOST_RESET_NS * CLK_MHZ + 999) / 1000;

  // Address/control byte fields
  localparam int AC_DIR_BIT = 7;
  localparam int AC_SPACE_BIT = 5;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Location map, bit 5 set means clock-register space
  localparam logic [5:0] STATUS_ADDR = 6'h30;
  localparam logic [5:0] CLK_CTRL_ADDR = 6'h31;
  localparam logic [5:0] INT_CTRL_ADDR = 6'h32;
  localparam logic [5:0] RAM_WRAP_ADDR = 6'h00;
  localparam logic [5:0] CLK_WRAP_ADDR = 6'h20;

  // Status flag positions, bit 7 reads zero
  localparam int ST_WDOG = 6;
  localparam int ST_TEST = 5;
  localparam int ST_FIRST_UP = 4;
  localparam int ST_ANY_IRQ = 3;
  localparam int ST_PSENSE = 2;
  localparam int ST_ALARM = 1;
  localparam int ST_PERIODIC = 0;
  localparam logic [7:0] STATUS_RESET = 8'h10;

  // Interrupt control bits
  localparam int IC_WDOG_EN = 7;
  localparam int IC_POWER_DOWN = 6;
  localparam logic [7:0] INT_CTRL_RESET = 8'h00;
  localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
endpackage

// ---- hdl/rtc_serial_port_status.sv ----
// Serial slave port, status flags, watchdog and power-down of the clock/RAM
// Operation
// - Watchdog flag goes high when the watchdog decides the host failed.
// - Power-on reset sets the power-lost flag: clock and RAM need setup.
// - Any-interrupt flag rises when power sense, alarm or periodic is valid.
// - Power-sense flag goes high when the power-sense circuit interrupts.
// - Alarm flag goes high when time counters equal alarm counters.
// - Each periodic interrupt event sets the periodic flag.
// - Power-on reset clears every flag except power-lost, which it sets.
// - Reading status clears all flags except the power-sense and test flags.
// - Serial clock captures input bits and advances output bits.
// - Every byte travels most significant bit first.
// - Chip enable low resets the serial logic and disables the output.
// - Serial clock level at chip enable rise is the idle polarity.
// - One clock per bit, bytes of 8; capture on strobe, change on shift.
// - First byte after chip enable rise is the address/control byte.
// - Address byte bit 7: one selects write cycles, zero read cycles.
// - Bit 5 picks clock or RAM space; bits 4 to 0 are the location.
// - Data bytes follow the address byte: device drives reads only.
// - Latched location increments after each data byte while enabled.
// - Past 1FH the location wraps to 00H in RAM, 20H in clock space.
// - With watchdog on, missing chip-enable toggles assert host reset.
// - Power-down holds host reset and clock output low, port disabled.
// - Output stays off until a read byte is ready, and during writes.
// - Watchdog armed by a control bit; status read before re-arming.
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_port_status #(
  parameter int WDOG_CYCLES = rtc_port_pkg::WDOG_CYCLES
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // Serial pins
  input wire logic ce_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe,
  // Supply sense pin
  input wire logic system_supply_sense,
  // Event sources from timekeeping logic
  input wire logic alarm_match_in,
  input wire logic periodic_tick_in,
  input wire logic power_sense_event_in,
  input wire logic test_mode_in,
  // Control outputs
  output logic host_reset_out_n,
  output logic clk_out_en,
  output logic supply_switch_out,
  output logic [7:0] int_ctrl_out,
  output logic [7:0] clk_ctrl_out
);
  // Pin synchronisers and edge history
  logic ce_meta, ce_s, ce_q;
  logic sck_meta, sck_s, sck_q;
  logic mosi_meta, mosi_s;
  logic sup_meta, sup_s, sup_q;
  // Serial engine state
  logic active_ff, idle_ff, have_addr_ff, wr_dir_ff, xfer_seen_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  logic [7:0] tx_ff;
  logic [5:0] addr_ff;
  logic miso_ff, miso_oe_ff;
  // Registers and storage
  logic [7:0] status_ff, int_ctrl_ff, clk_ctrl_ff;
  logic [7:0] mem_ff [64];
  // Watchdog and host reset
  logic [31:0] wd_cnt_ff;
  logic [7:0] rst_cnt_ff;
  logic host_rst_n_ff, clk_en_ff, supply_ff;
  // Decode
  logic ce_rise, ce_fall, sup_rise, sck_edge, lead_edge, trail_edge;
  logic byte_done, first_byte, load_rd, wr_en, status_rd, wd_trip, pd;
  logic [7:0] rx_byte, rd_data;
  logic [5:0] load_addr;

  // Next location, wrapping within the selected space
  function automatic logic [5:0] next_addr(input logic [5:0] a);
    next_addr = {a[5], a[4:0] + 5'h01};
  endfunction

  // Two-flop synchronisers, third flop for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ce_meta <= 1'b0;
      ce_s <= 1'b0;
      ce_q <= 1'b0;
      sck_meta <= 1'b0;
      sck_s <= 1'b0;
      sck_q <= 1'b0;
      mosi_meta <= 1'b0;
      mosi_s <= 1'b0;
      sup_meta <= 1'b1; // Supply pin idles high, no false edge
      sup_s <= 1'b1;
      sup_q <= 1'b1;
    end else begin
      ce_meta <= ce_in;
      ce_s <= ce_meta;
      ce_q <= ce_s;
      sck_meta <= sck_in;
      sck_s <= sck_meta;
      sck_q <= sck_s;
      mosi_meta <= mosi_in;
      mosi_s <= mosi_meta;
      sup_meta <= system_supply_sense;
      sup_s <= sup_meta;
      sup_q <= sup_s;
    end
  end

  // Edge and byte decode
  always_comb begin
    pd = int_ctrl_ff[rtc_port_pkg::IC_POWER_DOWN];
    ce_rise = ce_s & ~ce_q;
    ce_fall = ~ce_s & ce_q;
    sup_rise = sup_s & ~sup_q;
    sck_edge = sck_s ^ sck_q;
    lead_edge = active_ff & sck_edge & (sck_s != idle_ff);
    trail_edge = active_ff & sck_edge & (sck_s == idle_ff);
    rx_byte = {shift_ff, mosi_s};
    byte_done = trail_edge & (bit_cnt_ff == rtc_port_pkg::LAST_BIT);
    first_byte = ~have_addr_ff;
    if (first_byte) begin
      load_addr = {rx_byte[rtc_port_pkg::AC_SPACE_BIT], rx_byte[4:0]};
    end else begin
      load_addr = next_addr(addr_ff);
    end
    load_rd = byte_done &
      (first_byte ? ~rx_byte[rtc_port_pkg::AC_DIR_BIT] : ~wr_dir_ff);
    wr_en = byte_done & ~first_byte & wr_dir_ff;
    status_rd = load_rd & (load_addr == rtc_port_pkg::STATUS_ADDR);
  end

  // Read data mux for the byte about to be shifted out
  always_comb begin
    unique case (load_addr)
      rtc_port_pkg::STATUS_ADDR: rd_data = status_ff;
      rtc_port_pkg::CLK_CTRL_ADDR: rd_data = clk_ctrl_ff;
      rtc_port_pkg::INT_CTRL_ADDR: rd_data = int_ctrl_ff;
      default: rd_data = mem_ff[load_addr];
    endcase
  end

  // Serial engine: held in reset while disabled or powered down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_ff <= 1'b0;
      idle_ff <= 1'b0;
      have_addr_ff <= 1'b0;
      wr_dir_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      tx_ff <= 8'h00;
      addr_ff <= 6'h00;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else if (!ce_s || pd) begin
      active_ff <= 1'b0;
      have_addr_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      miso_oe_ff <= 1'b0;
      miso_ff <= 1'b0;
    end else if (ce_rise) begin
      idle_ff <= sck_s;
      active_ff <= 1'b1;
    end else if (trail_edge) begin
      shift_ff <= rx_byte[6:0];
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done) begin
        have_addr_ff <= 1'b1;
        if (first_byte) begin
          wr_dir_ff <= rx_byte[rtc_port_pkg::AC_DIR_BIT];
        end
        addr_ff <= load_addr;
        if (load_rd) begin
          tx_ff <= rd_data;
          miso_oe_ff <= 1'b1;
        end
      end
    end else if (lead_edge && miso_oe_ff) begin
      miso_ff <= tx_ff[7];
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // Transfer seen during this enable, for the watchdog
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xfer_seen_ff <= 1'b0;
    end else if (ce_rise) begin
      xfer_seen_ff <= 1'b0;
    end else if (trail_edge) begin
      xfer_seen_ff <= 1'b1;
    end
  end

  // RAM and clock-space storage
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[addr_ff] <= rx_byte;
    end
  end

  // Control registers; supply return ends power-down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_ctrl_ff <= rtc_port_pkg::INT_CTRL_RESET;
      clk_ctrl_ff <= rtc_port_pkg::CLK_CTRL_RESET;
    end else begin
      if (wr_en && addr_ff == rtc_port_pkg::INT_CTRL_ADDR) begin
        int_ctrl_ff <= rx_byte;
      end else if (sup_rise) begin
        int_ctrl_ff[rtc_port_pkg::IC_POWER_DOWN] <= 1'b0;
      end
      if (wr_en && addr_ff == rtc_port_pkg::CLK_CTRL_ADDR) begin
        clk_ctrl_ff <= rx_byte;
      end
    end
  end

  // Status flags: set wins over clear-on-read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= rtc_port_pkg::STATUS_RESET;
    end else begin
      if (status_rd) begin
        status_ff[rtc_port_pkg::ST_WDOG] <= 1'b0;
        status_ff[rtc_port_pkg::ST_FIRST_UP] <= 1'b0;
        status_ff[rtc_port_pkg::ST_ANY_IRQ] <= 1'b0;
        status_ff[rtc_port_pkg::ST_ALARM] <= 1'b0;
        status_ff[rtc_port_pkg::ST_PERIODIC] <= 1'b0;
      end
      status_ff[7] <= 1'b0;
      status_ff[rtc_port_pkg::ST_TEST] <= test_mode_in;
      if (wd_trip) begin
        status_ff[rtc_port_pkg::ST_WDOG] <= 1'b1;
      end
      if (power_sense_event_in) begin
        status_ff[rtc_port_pkg::ST_PSENSE] <= 1'b1;
      end
      if (alarm_match_in) begin
        status_ff[rtc_port_pkg::ST_ALARM] <= 1'b1;
      end
      if (periodic_tick_in) begin
        status_ff[rtc_port_pkg::ST_PERIODIC] <= 1'b1;
      end
      if (power_sense_event_in || alarm_match_in || periodic_tick_in) begin
        status_ff[rtc_port_pkg::ST_ANY_IRQ] <= 1'b1;
      end
    end
  end

  // Watchdog timer, restarted by a chip-enable toggle with no transfer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_ff <= 32'h0;
    end else if (!int_ctrl_ff[rtc_port_pkg::IC_WDOG_EN] ||
                 status_ff[rtc_port_pkg::ST_WDOG] || pd) begin
      wd_cnt_ff <= 32'h0;
    end else if (ce_fall && !xfer_seen_ff) begin
      wd_cnt_ff <= 32'h0;
    end else if (wd_trip) begin
      wd_cnt_ff <= 32'h0;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 32'h1;
    end
  end

  assign wd_trip = int_ctrl_ff[rtc_port_pkg::IC_WDOG_EN] &
    ~status_ff[rtc_port_pkg::ST_WDOG] & ~pd & ~(ce_fall & ~xfer_seen_ff) &
    (wd_cnt_ff == 32'(WDOG_CYCLES - 1));

  // Host reset pulse, clock enable and supply switch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt_ff <= 8'h00;
      host_rst_n_ff <= 1'b1;
      clk_en_ff <= 1'b1;
      supply_ff <= 1'b1;
    end else begin
      if (wd_trip) begin
        rst_cnt_ff <= 8'(rtc_port_pkg::HOST_RESET_CYCLES);
      end else if (rst_cnt_ff != 8'h00) begin
        rst_cnt_ff <= rst_cnt_ff - 8'h01;
      end
      host_rst_n_ff <= ~(pd | wd_trip | (rst_cnt_ff > 8'h01));
      clk_en_ff <= ~pd;
      supply_ff <= ~pd;
    end
  end

  // Outputs straight from flops
  assign miso_out = miso_ff;
  assign miso_oe = miso_oe_ff;
  assign host_reset_out_n = host_rst_n_ff;
  assign clk_out_en = clk_en_ff;
  assign supply_switch_out = supply_ff;
  assign int_ctrl_out = int_ctrl_ff;
  assign clk_ctrl_out = clk_ctrl_ff;

  // Checks
  AST_MISO_OFF: assert property (@(posedge clk) disable iff (!rstn)
    !ce_s |=> !miso_oe_ff) else $error("output driven while disabled");
  AST_WRITE_QUIET: assert property (@(posedge clk) disable iff (!rstn)
    (have_addr_ff && wr_dir_ff) |-> !miso_oe_ff)
    else $error("output driven during write");
  AST_IDLE_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
    (ce_rise && !pd) |=> (idle_ff == $past(sck_s)) && active_ff)
    else $error("idle polarity not captured");
  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rstn)
    (lead_edge && miso_oe_ff && ce_s && !pd && !ce_rise && !trail_edge)
    |=> miso_ff == $past(tx_ff[7])) else $error("bit order wrong");
  AST_WRAP_CLOCK: assert property (@(posedge clk) disable iff (!rstn)
    (byte_done && have_addr_ff && ce_s && !pd && addr_ff == 6'h3f)
    |=> addr_ff == rtc_port_pkg::CLK_WRAP_ADDR)
    else $error("clock space wrap wrong");
  AST_WRAP_RAM: assert property (@(posedge clk) disable iff (!rstn)
    (byte_done && have_addr_ff && ce_s && !pd && addr_ff == 6'h1f)
    |=> addr_ff == rtc_port_pkg::RAM_WRAP_ADDR)
    else $error("RAM wrap wrong");
  AST_CLEAR_ON_READ: assert property (@(posedge clk) disable iff (!rstn)
    (status_rd && !alarm_match_in && !periodic_tick_in)
    |=> !status_ff[rtc_port_pkg::ST_ALARM] &&
        !status_ff[rtc_port_pkg::ST_PERIODIC] &&
        !status_ff[rtc_port_pkg::ST_FIRST_UP])
    else $error("flags not cleared by read");
  AST_PSENSE_KEEP: assert property (@(posedge clk) disable iff (!rstn)
    (status_rd && status_ff[rtc_port_pkg::ST_PSENSE])
    |=> status_ff[rtc_port_pkg::ST_PSENSE])
    else $error("power-sense flag lost on read");
  AST_ALARM_SET: assert property (@(posedge clk) disable iff (!rstn)
    alarm_match_in |=> status_ff[rtc_port_pkg::ST_ALARM] &&
      status_ff[rtc_port_pkg::ST_ANY_IRQ]) else $error("alarm flag not set");
  AST_PERIODIC_SET: assert property (@(posedge clk) disable iff (!rstn)
    periodic_tick_in |=> status_ff[rtc_port_pkg::ST_PERIODIC])
    else $error("periodic flag not set");
  AST_ANY_SET: assert property (@(posedge clk) disable iff (!rstn)
    power_sense_event_in |=> status_ff[rtc_port_pkg::ST_ANY_IRQ] &&
      status_ff[rtc_port_pkg::ST_PSENSE]) else $error("interrupt flag missed");
  AST_POWER_DOWN: assert property (@(posedge clk) disable iff (!rstn)
    pd |=> !host_rst_n_ff && !clk_en_ff && !supply_ff && !miso_oe_ff)
    else $error("power-down outputs wrong");
  AST_WDOG_RESET: assert property (@(posedge clk) disable iff (!rstn)
    wd_trip |=> !host_rst_n_ff [*2] ##1 status_ff[rtc_port_pkg::ST_WDOG] ||
      !host_rst_n_ff) else $error("watchdog reset missing");
endmodule
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// Serial bus master model: chip enable, serial clock and data out
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Serial pins toward the device
  output logic ce,
  output logic sck,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic pol;
  logic oe_seen;

  // Deselected, clock parked low
  initial begin
    pol = 1'b0;
    ce = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
    oe_seen = 1'b0;
  end

  // Park clock at idle level before select so the level is stable
  task automatic open_frame(input logic p);
    pol = p;
    sck <= p;
    #40;
    ce <= 1'b1;
    oe_seen = 1'b0;
    #40;
  endtask

  // One byte, MSB first; data moves on the shift edge, read at strobe
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= ~pol;
      mosi <= tx[i];
      #62.5;
      sck <= pol;
      rx[i] = miso;
      oe_seen = oe_seen | miso_oe;
      #62.5;
    end
  endtask

  // Deselect; data line no longer holds the last bit
  task automatic close_frame();
    #40;
    ce <= 1'b0;
    mosi <= ~mosi;
    #100;
  endtask

  // Chip enable pulse with no clock activity, keeps the watchdog quiet
  task automatic toggle_ce();
    ce <= 1'b1;
    #100;
    ce <= 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the serial port and status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic alarm = 1'b0, tick = 1'b0, psense = 1'b0, test_mode = 1'b0;
  logic supply = 1'b1;
  wire logic ce, sck, mosi, miso_out, miso_oe;
  wire logic host_reset_out_n, clk_out_en, supply_switch_out;
  wire logic [7:0] int_ctrl_out, clk_ctrl_out;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] rbuf [4];
  logic [7:0] junk;

  always #2 clk = ~clk;

  spi_host_model host (.ce(ce), .sck(sck), .mosi(mosi), .miso(miso_out),
    .miso_oe(miso_oe));

  rtc_serial_port_status #(.WDOG_CYCLES(200)) u_dut (
    .clk(clk), .rstn(rstn), .ce_in(ce), .sck_in(sck), .mosi_in(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe), .system_supply_sense(supply),
    .alarm_match_in(alarm), .periodic_tick_in(tick),
    .power_sense_event_in(psense), .test_mode_in(test_mode),
    .host_reset_out_n(host_reset_out_n), .clk_out_en(clk_out_en),
    .supply_switch_out(supply_switch_out), .int_ctrl_out(int_ctrl_out),
    .clk_ctrl_out(clk_ctrl_out));

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Address byte then n data bytes; output enable checked per direction
  task automatic access(input logic [7:0] ac, input logic [7:0] wd [4],
                        input int n, input logic p);
    host.open_frame(p);
    host.xfer(ac, junk);
    for (int k = 0; k < n; k++) begin
      host.xfer(wd[k], rbuf[k]);
    end
    if (ac[7]) `CHK(host.oe_seen, 1'b0)
    else `CHK(miso_oe, 1'b1)
    host.close_frame();
    `CHK(miso_oe, 1'b0)
  endtask

  // Status read at location 30H, one byte
  task automatic rd_status(input logic [7:0] exp);
    access(8'h30, '{8'h00, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
    `CHK(rbuf[0], exp)
  endtask

  // One-cycle pulse on an event source
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: alarm <= 1'b1;
      1: tick <= 1'b1;
      default: psense <= 1'b1;
    endcase
    @(posedge clk);
    alarm <= 1'b0;
    tick <= 1'b0;
    psense <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Bounded wait for a host reset level
  task automatic wait_reset(input logic val);
    int k;
    for (k = 0; k < 400 && host_reset_out_n !== val; k++) @(posedge clk);
    if (k == 400) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // Power-on values and clear-on-read of first-time-up
  task automatic s_reset();
    `CHK(int_ctrl_out, 8'h00)
    `CHK(clk_ctrl_out, 8'h00)
    `CHK(host_reset_out_n, 1'b1)
    rd_status(8'h10);
    rd_status(8'h00);
  endtask

  // Bursts across both wrap points, both clock polarities
  task automatic s_burst();
    access(8'h9e, '{8'h11, 8'h22, 8'h33, 8'h00}, 3, 1'b1);
    access(8'h1e, '{8'h00, 8'h00, 8'h00, 8'h00}, 3, 1'b0);
    `CHK(rbuf[0], 8'h11)
    `CHK(rbuf[1], 8'h22)
    `CHK(rbuf[2], 8'h33)
    access(8'hbf, '{8'ha5, 8'h5a, 8'h00, 8'h00}, 2, 1'b0);
    access(8'h20, '{8'h00, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    `CHK(rbuf[0], 8'h5a)
    access(8'h3f, '{8'h00, 8'h00, 8'h00, 8'h00}, 2, 1'b1);
    `CHK(rbuf[0], 8'ha5)
    `CHK(rbuf[1], 8'h5a)
    access(8'hb1, '{8'h5c, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
    `CHK(clk_ctrl_out, 8'h5c)
    access(8'h31, '{8'h00, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    `CHK(rbuf[0], 8'h5c)
  endtask

  // Each event source, any-interrupt, sticky power-sense, test mode
  task automatic s_events();
    pulse(0);
    rd_status(8'h0a);
    pulse(1);
    rd_status(8'h09);
    test_mode <= 1'b1;
    pulse(2);
    rd_status(8'h2c);
    rd_status(8'h24);
    test_mode <= 1'b0;
    repeat (4) @(posedge clk);
    rd_status(8'h04);
  endtask

  // Watchdog quiet while toggled, fires when toggling stops
  task automatic s_watchdog();
    access(8'hb2, '{8'h80, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
    `CHK(int_ctrl_out, 8'h80)
    for (int k = 0; k < 5; k++) begin
      host.toggle_ce();
      `CHK(host_reset_out_n, 1'b1)
    end
    wait_reset(1'b0);
    `CHK(host_reset_out_n, 1'b0)
    access(8'hb2, '{8'h00, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
    rd_status(8'h44);
  endtask

  // Power-down disables port and outputs; supply return ends it
  task automatic s_powerdown();
    access(8'hb2, '{8'h40, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    `CHK(host_reset_out_n, 1'b0)
    `CHK(clk_out_en, 1'b0)
    `CHK(supply_switch_out, 1'b0)
    host.open_frame(1'b0);
    host.xfer(8'h30, junk);
    host.xfer(8'h00, junk);
    `CHK(miso_oe, 1'b0)
    host.close_frame();
    @(posedge clk);
    supply <= 1'b0;
    repeat (10) @(posedge clk);
    supply <= 1'b1;
    wait_reset(1'b1);
    repeat (4) @(posedge clk);
    `CHK(clk_out_en, 1'b1)
    `CHK(supply_switch_out, 1'b1)
    `CHK(int_ctrl_out, 8'h00)
    rd_status(8'h04);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    s_reset();
    s_burst();
    s_events();
    s_watchdog();
    s_powerdown();
    report_and_stop();
  end
endmodule
`default_nettype wire
